// ### verilog/sbs_port.sv
// pipelined burst sram port: input registers, selects, writes, burst
`timescale 1ns/1ps
`default_nettype none
`include "sbs_port_consts.svh"

module sbs_port (
  input  wire logic                              clk_sys,
  input  wire logic                              nrst,
  input  wire logic [`SBS_ADDR_W-1:`SBS_LOW_W]   addr_upper,
  input  wire logic                              addr_bit_one,
  input  wire logic                              addr_bit_zero,
  input  wire logic                              chip_select_n,
  input  wire logic                              chip_select_hi,
  input  wire logic                              proc_addr_strobe_n,
  input  wire logic                              ctrl_addr_strobe_n,
  input  wire logic                              burst_step_n,
  input  wire logic                              byte_write_gate_n,
  input  wire logic                              byte_lane0_write_n,
  input  wire logic                              byte_lane1_write_n,
  input  wire logic                              global_write_n,
  input  wire logic                              burst_order_sel,
  input  wire logic [`SBS_LANE_W-1:0]            data_lane_zero_i,
  output logic      [`SBS_LANE_W-1:0]            data_lane_zero_o,
  output logic                                   data_lane_zero_oe,
  input  wire logic [`SBS_LANE_W-1:0]            data_lane_one_i,
  output logic      [`SBS_LANE_W-1:0]            data_lane_one_o,
  output logic                                   data_lane_one_oe
);

  localparam sbs_pkg::sbs_pins_t PINS_RST = '{
    addr:   '0,
    din:    '0,
    ce_n:   `SBS_N_IDLE,
    ce2:    `SBS_H_IDLE,
    proc_addr_strobe_n_n: `SBS_N_IDLE,
    ctrl_addr_strobe_n_n: `SBS_N_IDLE,
    adv_n:  `SBS_N_IDLE,
    bwe_n:  `SBS_N_IDLE,
    bw_n:   '1,
    gw_n:   `SBS_N_IDLE,
    order:  `SBS_ORD_RST
  };

  localparam sbs_pkg::sbs_state_t STATE_RST = '{
    pins:  PINS_RST,
    phase: sbs_pkg::SBS_IDLE,
    hi:    '0,
    rd_v:  1'h0,
    dout:  '0,
    oe:    1'h0
  };

  sbs_pkg::sbs_state_t              s_q;
  sbs_pkg::sbs_state_t              s_d;
  sbs_pkg::sbs_pins_t               p;

  logic                             sel;
  logic                             proc_addr_strobe_n_go;
  logic                             ctrl_addr_strobe_n_go;
  logic [`SBS_LANES-1:0]            byte_we;
  logic                             hiz;
  logic                             ctr_load;
  logic                             ctr_step;
  logic [`SBS_LOW_W-1:0]            ctr_low;
  logic                             mem_en;
  logic [`SBS_LANES-1:0]            mem_we;
  logic [`SBS_ADDR_W-1:`SBS_LOW_W]  mem_hi;
  logic [`SBS_ADDR_W-1:0]           mem_addr;
  logic [`SBS_DATA_W-1:0]           mem_rdata;

  assign p = s_q.pins;

  // new upper bits go straight to the array on a load cycle
  assign mem_hi   = ctr_load ? p.addr[`SBS_ADDR_W-1:`SBS_LOW_W] : s_q.hi;
  assign mem_addr = {mem_hi, ctr_low};

  always_comb begin
    s_d = s_q;

    // all synchronous pins land in one register stage
    s_d.pins.addr   = {addr_upper, addr_bit_one, addr_bit_zero};
    s_d.pins.din    = {data_lane_one_i, data_lane_zero_i};
    s_d.pins.ce_n   = chip_select_n;
    s_d.pins.ce2    = chip_select_hi;
    s_d.pins.proc_addr_strobe_n_n = proc_addr_strobe_n;
    s_d.pins.ctrl_addr_strobe_n_n = ctrl_addr_strobe_n;
    s_d.pins.adv_n  = burst_step_n;
    s_d.pins.bwe_n  = byte_write_gate_n;
    s_d.pins.bw_n   = {byte_lane1_write_n, byte_lane0_write_n};
    s_d.pins.gw_n   = global_write_n;
    s_d.pins.order  = burst_order_sel;

    sel     = !p.ce_n && p.ce2;
    // processor strobe is dead unless the primary select is low
    proc_addr_strobe_n_go = !p.proc_addr_strobe_n_n && !p.ce_n;
    ctrl_addr_strobe_n_go = !p.ctrl_addr_strobe_n_n && !proc_addr_strobe_n_go;

    for (int i = 0; i < `SBS_LANES; i++) begin
      byte_we[i] = !p.gw_n || (!p.bwe_n && !p.bw_n[i]);
    end

    ctr_load = 1'h0;
    ctr_step = 1'h0;
    mem_en   = 1'h0;
    mem_we   = '0;

    if (proc_addr_strobe_n_go || ctrl_addr_strobe_n_go) begin
      if (sel) begin
        s_d.phase = sbs_pkg::SBS_BURST;
        s_d.hi    = p.addr[`SBS_ADDR_W-1:`SBS_LOW_W];
        ctr_load  = 1'h1;
        mem_en    = 1'h1;
        // processor-started cycles always read first
        if (ctrl_addr_strobe_n_go) begin
          mem_we = byte_we;
        end
      end else begin
        // strobe with a failed select drops out of the burst
        s_d.phase = sbs_pkg::SBS_IDLE;
      end
    end else begin
      case (s_q.phase)
        sbs_pkg::SBS_BURST: begin
          // a wait cycle still reads or writes at the held address
          ctr_step = !p.adv_n;
          mem_en   = 1'h1;
          mem_we   = byte_we;
        end
        sbs_pkg::SBS_IDLE: begin
          mem_en = 1'h0;
        end
        default: begin
          s_d.phase = sbs_pkg::SBS_IDLE;
        end
      endcase
    end

    s_d.rd_v = mem_en && (mem_we == '0);
    s_d.dout = mem_rdata;

    // float the pins whenever this cycle carries a write
    // same lane decode as the write path, though a processor-started cycle floats the pins without writing
    hiz      = |byte_we;
    s_d.oe   = s_q.rd_v && !hiz;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  sbs_burst_ctr u_ctr (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .load     (ctr_load),
    .load_low (p.addr[`SBS_LOW_W-1:0]),
    .step     (ctr_step),
    .linear   (!p.order),
    .addr_low (ctr_low)
  );

  sbs_mem_array #(
    .ADDR_W (`SBS_ADDR_W),
    .LANES  (`SBS_LANES),
    .LANE_W (`SBS_LANE_W)
  ) u_mem (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .en      (mem_en),
    .we      (mem_we),
    .addr    (mem_addr),
    .wdata   (p.din),
    .rdata   (mem_rdata)
  );

  assign data_lane_zero_o  = s_q.dout[`SBS_LANE_W-1:0];
  assign data_lane_one_o   = s_q.dout[`SBS_DATA_W-1:`SBS_LANE_W];
  assign data_lane_zero_oe = s_q.oe;
  assign data_lane_one_oe  = s_q.oe;

endmodule : sbs_port

`default_nettype wire

// ### inc/sbs_port_consts.svh
// constants for the synchronous burst sram port
`ifndef SBS_PORT_CONSTS_SVH
`define SBS_PORT_CONSTS_SVH

`define SBS_ADDR_W   19
`define SBS_LOW_W    2
`define SBS_LANE_W   9
`define SBS_LANES    2
`define SBS_DATA_W   18
`define SBS_N_IDLE   1'h1
`define SBS_H_IDLE   1'h0
`define SBS_ORD_RST  1'h1

`endif

// ### inc/sbs_pkg.sv
// types shared by the burst sram port modules
`default_nettype none
`include "sbs_port_consts.svh"

package sbs_pkg;

  typedef enum logic {
    SBS_IDLE,
    SBS_BURST
  } sbs_phase_t;

  typedef struct packed {
    logic [`SBS_ADDR_W-1:0] addr;
    logic [`SBS_DATA_W-1:0] din;
    logic                   ce_n;
    logic                   ce2;
    logic                   proc_addr_strobe_n_n;
    logic                   ctrl_addr_strobe_n_n;
    logic                   adv_n;
    logic                   bwe_n;
    logic [`SBS_LANES-1:0]  bw_n;
    logic                   gw_n;
    logic                   order;
  } sbs_pins_t;

  typedef struct packed {
    logic [`SBS_LOW_W-1:0] start;
    logic [`SBS_LOW_W-1:0] cnt;
  } sbs_burst_t;

  typedef struct packed {
    sbs_pins_t                         pins;
    sbs_phase_t                        phase;
    logic [`SBS_ADDR_W-1:`SBS_LOW_W]   hi;
    logic                              rd_v;
    logic [`SBS_DATA_W-1:0]            dout;
    logic                              oe;
  } sbs_state_t;

endpackage : sbs_pkg

`default_nettype wire

// ### verilog/sbs_burst_ctr.sv
// two-bit burst address counter, linear or interleaved order
`timescale 1ns/1ps
`default_nettype none
`include "sbs_port_consts.svh"

module sbs_burst_ctr (
  input  wire logic                  clk_sys,
  input  wire logic                  nrst,
  input  wire logic                  load,
  input  wire logic [`SBS_LOW_W-1:0] load_low,
  input  wire logic                  step,
  input  wire logic                  linear,
  output logic      [`SBS_LOW_W-1:0] addr_low
);

  sbs_pkg::sbs_burst_t s_q;
  sbs_pkg::sbs_burst_t s_d;

  // group of four words, so the sum wraps inside the group by width
  function automatic logic [`SBS_LOW_W-1:0] burst_seq(
    input logic [`SBS_LOW_W-1:0] start,
    input logic [`SBS_LOW_W-1:0] cnt,
    input logic                  lin
  );
    burst_seq = lin ? start + cnt : start ^ cnt;
  endfunction : burst_seq

  always_comb begin
    s_d = s_q;
    if (load) begin
      s_d.start = load_low;
      s_d.cnt   = '0;
    end else if (step) begin
      s_d.cnt = s_q.cnt + `SBS_LOW_W'(1);
    end
    // address of the access in this cycle, already advanced
    addr_low = burst_seq(s_d.start, s_d.cnt, linear);
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : sbs_burst_ctr

`default_nettype wire

// ### verilog/sbs_mem_array.sv
// storage array with per-lane write enables and registered read
`timescale 1ns/1ps
`default_nettype none

module sbs_mem_array #(
  parameter int ADDR_W = 19,
  parameter int LANES  = 2,
  parameter int LANE_W = 9
) (
  input  wire logic                      clk_sys,
  input  wire logic                      nrst,
  input  wire logic                      en,
  input  wire logic [LANES-1:0]          we,
  input  wire logic [ADDR_W-1:0]         addr,
  input  wire logic [LANES*LANE_W-1:0]   wdata,
  output logic      [LANES*LANE_W-1:0]   rdata
);

  logic [LANES*LANE_W-1:0] mem [2**ADDR_W];

  // no reset on the array; contents are undefined until written
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < LANES; i++) begin
      // lane 0 is the first byte, each lane has its own enable
      if (en && we[i]) begin
        mem[addr][i*LANE_W +: LANE_W] <= wdata[i*LANE_W +: LANE_W];
      end
    end
  end

  // read returns the word before any write in the same cycle
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdata <= '0;
    end else if (en) begin
      rdata <= mem[addr];
    end
  end

endmodule : sbs_mem_array

`default_nettype wire

// ### testbench/sbs_port_asserts.sv
// pin-level assertions for the burst sram port
`timescale 1ns/1ps
`default_nettype none
module sbs_port_asserts (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic chip_select_n,
  input wire logic chip_select_hi,
  input wire logic proc_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic burst_step_n,
  input wire logic byte_write_gate_n,
  input wire logic byte_lane0_write_n,
  input wire logic byte_lane1_write_n,
  input wire logic global_write_n,
  input wire logic data_lane_zero_oe,
  input wire logic data_lane_one_oe
);
  logic wr, rd, dsl, go, oe;
  assign oe  = data_lane_zero_oe;
  assign wr  = !global_write_n | (!byte_write_gate_n & !(byte_lane0_write_n & byte_lane1_write_n));
  assign rd  = !chip_select_n & chip_select_hi
               & (!proc_addr_strobe_n | (!ctrl_addr_strobe_n & !wr));
  // a failed select also ends any burst, so the port goes quiet
  assign dsl = !ctrl_addr_strobe_n & (chip_select_n | !chip_select_hi);
  assign go  = ctrl_addr_strobe_n & (proc_addr_strobe_n | chip_select_n);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  property p_pair; oe == data_lane_one_oe; endproperty
  a_pair: assert property (p_pair) else $error("lane enables differ");
  property p_read; rd ##1 !wr |-> ##2 oe; endproperty
  a_read: assert property (p_read) else $error("read not answered");
  property p_proc; (!proc_addr_strobe_n & !chip_select_n & chip_select_hi & !global_write_n)
    ##1 !wr |-> ##2 data_lane_one_oe; endproperty
  a_proc: assert property (p_proc) else $error("proc start not a read");
  property p_gate; (rd & byte_write_gate_n & !byte_lane0_write_n) ##1 !wr |-> ##2 oe; endproperty
  a_gate: assert property (p_gate) else $error("ungated lane wrote");
  property p_write; wr |-> ##2 !oe; endproperty
  a_write: assert property (p_write) else $error("pins driven on write");
  property p_desel; dsl |-> ##3 !oe; endproperty
  a_desel: assert property (p_desel) else $error("deselect still reads");
  property p_glob; (!global_write_n & byte_write_gate_n & byte_lane0_write_n
    & byte_lane1_write_n) |-> ##2 !data_lane_one_oe; endproperty
  a_glob: assert property (p_glob) else $error("global write not floated");
  property p_ign; dsl ##1 (!proc_addr_strobe_n & chip_select_n & ctrl_addr_strobe_n)
    |-> ##3 !oe; endproperty
  a_ign: assert property (p_ign) else $error("ungated proc strobe taken");
  property p_wait; rd ##1 (go & burst_step_n & !wr) [*2] |-> ##1 oe [*2]; endproperty
  a_wait: assert property (p_wait) else $error("wait cycle dropped");
endmodule : sbs_port_asserts
`default_nettype wire

// ### testbench/sbs_ctrl_model.sv
// controller side of the data pins: write data out, floating bus otherwise
`timescale 1ns/1ps
`default_nettype none
module sbs_ctrl_model (
  input  wire logic               clk_sys,
  input  wire logic               nrst,
  input  wire sbs_pkg::sbs_pins_t req,
  input  wire logic               dev_oe,
  input  wire logic [17:0]        dev_q,
  output logic      [17:0]        bus
);
  logic        drv;
  logic [17:0] last_q;
  assign drv = !req.gw_n | (!req.bwe_n & !(&req.bw_n));
  // undriven bus toggles so a stale value never looks valid
  assign bus = dev_oe ? dev_q : (drv ? req.din : ~last_q);
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) last_q <= 18'h0;
    else last_q <= bus;
  end
endmodule : sbs_ctrl_model
`default_nettype wire

// ### testbench/tb_sync_burst_sram_port.sv
// self-checking bench for the burst sram port
`timescale 1ns/1ps
`default_nettype none
module tb_sync_burst_sram_port;
  typedef struct packed {
    logic gw, bg, l0, l1, rd, ps, cn, ch;
    logic [18:0] a;
    logic [17:0] d;
  } sbs_row_t;
  logic               clk_sys, nrst, zoe, ooe;
  logic [8:0]         zo, oo;
  logic [17:0]        bus;
  sbs_pkg::sbs_pins_t p, dsl;
  sbs_row_t           rows [12];
  int                 num_errors, tests_run, cyc_cnt;

  sbs_port dut (.clk_sys(clk_sys), .nrst(nrst), .addr_upper(p.addr[18:2]),
    .addr_bit_one(p.addr[1]), .addr_bit_zero(p.addr[0]), .chip_select_n(p.ce_n),
    .chip_select_hi(p.ce2), .proc_addr_strobe_n(p.proc_addr_strobe_n_n), .ctrl_addr_strobe_n(p.ctrl_addr_strobe_n_n),
    .burst_step_n(p.adv_n), .byte_write_gate_n(p.bwe_n), .byte_lane0_write_n(p.bw_n[0]),
    .byte_lane1_write_n(p.bw_n[1]), .global_write_n(p.gw_n), .burst_order_sel(p.order),
    .data_lane_zero_i(bus[8:0]), .data_lane_zero_o(zo), .data_lane_zero_oe(zoe),
    .data_lane_one_i(bus[17:9]), .data_lane_one_o(oo), .data_lane_one_oe(ooe));
  sbs_ctrl_model ctl (.clk_sys(clk_sys), .nrst(nrst), .req(p), .dev_oe(zoe),
    .dev_q({oo, zo}), .bus(bus));

  function automatic sbs_pkg::sbs_pins_t mk(input sbs_row_t r);
    return {r.a, r.d, r.cn, r.ch, !r.ps, r.ps, 1'h1, r.bg, r.l1, r.l0, r.gw, 1'h1};
  endfunction : mk
  task automatic wrap_up;
    if (num_errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic eo, input logic [17:0] ed, input logic cd);
    tests_run++;
    if (zoe !== eo || ooe !== eo || (cd && {oo, zo} !== ed)) begin
      num_errors++;
      $display("unexpected at %0t: oe %b data %h", $time, zoe, {oo, zo});
    end
  endtask : chk
  task automatic cyc(input sbs_pkg::sbs_pins_t v);
    @(posedge clk_sys);
    #1;
    p = v;
  endtask : cyc
  task automatic op(input sbs_row_t r);
    cyc(mk(r));
    cyc(dsl);
    cyc(dsl);
    @(posedge clk_sys);
    #1;
    chk(r.rd, r.d, r.rd);
  endtask : op
  // two wait cycles, then three advances: burst steps 0,0,0,1,2,3 from the start word
  task automatic burst(input logic o, input logic [1:0] s);
    sbs_pkg::sbs_pins_t v;
    logic [1:0]         k;
    for (int j = 0; j < 9; j++) begin
      v = (j > 5) ? dsl : mk({8'hf9, 17'h10, s, 18'h0});
      v.order = o;
      if (j > 0 && j < 6) v.ctrl_addr_strobe_n_n = 1'h1;
      if (j > 0 && j < 6) v.adv_n = (j < 3);
      cyc(v);
      k = (j < 6) ? 2'h0 : 2'(j - 5);
      if (j > 2) chk(1'h1, {16'h0040, 2'(o ? s ^ k : s + k)}, 1'h1);
    end
  endtask : burst

  initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc_cnt++;
    if (cyc_cnt == 1000) begin
      num_errors++;
      wrap_up();
    end
  end
  initial begin
    nrst = 1'h0;
    dsl = mk({8'hf2, 37'h0});
    p = dsl;
    rows = '{{8'h71, 19'h00104, 18'h2a5a5}, {8'hf9, 19'h00104, 18'h2a5a5},
             {8'h91, 19'h00104, 18'h00011}, {8'hc9, 19'h00104, 18'h2a411},
             {8'ha1, 19'h00104, 18'h3fe00}, {8'hf9, 19'h00104, 18'h3fe11},
             {8'h71, 19'h7fffc, 18'h15555}, {8'hf9, 19'h7fffc, 18'h15555},
             {8'hf9, 19'h00104, 18'h3fe11}, {8'h7d, 19'h00104, 18'h3fe11},
             {8'hf7, 19'h00104, 18'h00000}, {8'hf0, 19'h00104, 18'h00000}};
    repeat (12) @(posedge clk_sys);
    #1;
    chk(1'h0, 18'h0, 1'h1);
    nrst = 1'h1;
    foreach (rows[i]) op(rows[i]);
    for (int i = 0; i < 4; i++) op({8'h71, 17'h10, 2'(i), 16'h0040, 2'(i)});
    burst(1'h0, 2'h1);
    burst(1'h1, 2'h1);
    burst(1'h1, 2'h2);
    // a write right behind a read must keep the pins released
    cyc(mk({8'hf9, 19'h00104, 18'h0}));
    cyc(mk({8'h71, 19'h00108, 18'h0aaaa}));
    cyc(dsl);
    @(posedge clk_sys);
    #1;
    chk(1'h0, 18'h0, 1'h0);
    op({8'hf9, 19'h00108, 18'h0aaaa});
    cyc(mk({8'hf9, 19'h00104, 18'h0}));
    cyc(dsl);
    cyc(dsl);
    @(posedge clk_sys);
    #1;
    nrst = 1'h0;
    #1;
    chk(1'h0, 18'h0, 1'h1);
    repeat (2) @(posedge clk_sys);
    #1;
    nrst = 1'h1;
    op({8'hf9, 19'h00104, 18'h3fe11});
    wrap_up();
  end
endmodule : tb_sync_burst_sram_port

bind sbs_port sbs_port_asserts chk_i (.clk_sys(clk_sys), .nrst(nrst),
  .chip_select_n(chip_select_n), .chip_select_hi(chip_select_hi),
  .proc_addr_strobe_n(proc_addr_strobe_n), .ctrl_addr_strobe_n(ctrl_addr_strobe_n),
  .burst_step_n(burst_step_n), .byte_write_gate_n(byte_write_gate_n),
  .byte_lane0_write_n(byte_lane0_write_n), .byte_lane1_write_n(byte_lane1_write_n),
  .global_write_n(global_write_n), .data_lane_zero_oe(data_lane_zero_oe),
  .data_lane_one_oe(data_lane_one_oe));
`default_nettype wire
